// ---- bench/lsc_glass_model.sv ----
// display glass stand-in: records which common lines were ever driven
// assumes clr is a one-cycle pulse from the bench in pclk domain
module lsc_glass_model (
  // clock and control
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       clr,
  // common pins and the ladder step on each
  input wire logic       led_mode,
  input wire logic       bias_third,
  input wire logic [7:0] com_drive,
  input wire logic [2:0] com_level [8],
  output logic     [7:0] com_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] top;
  logic [7:0] lit;
  // a selected common sits at an end of the ladder; mid steps mean unselected
  assign top = (led_mode || !bias_third) ? 3'd4 : 3'd3;
  always_comb begin
    for (int g = 0; g < 8; g++) begin
      lit[g] = com_drive[g] && ((com_level[g] == top) || (!led_mode && com_level[g] == 3'd0));
    end
  end
  // a real glass only integrates; the mask is what a frame lit up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      com_seen <= 8'h00;
    else if (clr)
      com_seen <= 8'h00;
    else
      com_seen <= com_seen | lit;
  end
endmodule

// ---- bench/lsc_scan_props.sv ----
// checker for register writes, pin gating and common scanning of lsc_scan
// assumes it is bound to lsc_scan and sees only that module's ports
module lsc_scan_props
  import lsc_pkg::*;
(
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pslverr,
  // pins and controls
  input wire logic [7:0]  port1_pin_display_en,
  input wire logic [7:0]  port2_pin_display_en,
  input wire logic [7:0]  port3_pin_display_en,
  input wire logic        bias_third,
  input wire logic        led_mode,
  input wire lsc_lvl_t    com_level [NUM_COM],
  input wire logic [NUM_COM-1:0] com_drive,
  input wire logic [NUM_SEG-1:0] seg_drive
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       wr_acc;
  logic [7:0] wdat;
  logic [NUM_COM-1:0] com_top;
  // only the selected common ever reaches the top ladder step
  always_comb begin
    for (int g = 0; g < NUM_COM; g++) begin
      com_top[g] = (com_level[g] == 3'd4);
    end
  end
  assign wr_acc = psel && penable && pwrite && ce && pstrb[0];
  assign wdat   = pwdata[7:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_port1_write: assert property (wr_acc && paddr == {2'b00, IDX_P1_EN, 2'b00} |=>
    port1_pin_display_en == $past(wdat)) else $error("port1 enables not written");
  a_port2_write: assert property (wr_acc && paddr == {2'b00, IDX_P2_EN, 2'b00} |=>
    port2_pin_display_en == $past(wdat)) else $error("port2 enables not written");
  a_port3_write: assert property (wr_acc && paddr == {2'b00, IDX_P3_EN, 2'b00} |=>
    port3_pin_display_en == $past(wdat)) else $error("port3 enables not written");
  a_bias_write: assert property (wr_acc && paddr == {2'b00, IDX_OUT_CTRL, 2'b00} |=>
    bias_third == $past(wdat[0])) else $error("bias select not written");
  a_type_write: assert property (wr_acc && paddr == {2'b00, IDX_SCAN_CTRL, 2'b00} |=>
    led_mode == $past(wdat[6])) else $error("display type not written");
  a_com_single: assert property ($onehot0(com_top))
    else $error("more than one common active");
  a_pin_gating: assert property ((com_drive & ~port1_pin_display_en) == 8'h00 &&
    (seg_drive[15:0] & ~{port3_pin_display_en, port2_pin_display_en}) == 16'h0000)
    else $error("disabled pin driven by scan");
  a_err_access: assert property (!penable |-> !pslverr)
    else $error("error response outside access phase");
endmodule

bind lsc_scan lsc_scan_props i_lsc_scan_props (.pclk, .presetn, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .pslverr, .port1_pin_display_en, .port2_pin_display_en,
  .port3_pin_display_en, .bias_third, .led_mode, .com_level, .com_drive, .seg_drive);

// ---- bench/testbench.sv ----
// self-checking bench for lsc_scan: apb master, random data, scan checks
// assumes a fast scan clock so a common slot lasts some 530 pclk cycles
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import lsc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 0;
  logic scan_clk_in = 0, er, bias_third, led_mode, pready, pslverr;
  logic [15:0] paddr = 0, lfsr = 16'hd7a4;
  logic [31:0] pwdata = 0, rd, prdata;
  logic [7:0] port1_pin_display_en, port2_pin_display_en, port3_pin_display_en, com_seen;
  logic [7:0] w [4], com_drive;
  logic [1:0] divider_resistance_eff;
  lsc_lvl_t com_level [NUM_COM];
  logic [NUM_SEG-1:0] seg_drive;
  logic [11:0] regs [5] = '{IDX_OUT_CTRL, IDX_P1_EN, IDX_P2_EN, IDX_P3_EN, IDX_SCAN_CTRL};
  int n_errors = 0, samples_checked = 0;
  always #12.5 pclk = ~pclk;
  always #103 scan_clk_in = ~scan_clk_in;
  lsc_scan i_lsc_scan (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .scan_clk_in, .port1_pin_display_en,
    .port2_pin_display_en, .port3_pin_display_en, .divider_resistance_eff, .bias_third,
    .led_mode, .com_level, .seg_level(), .com_drive, .seg_drive);
  lsc_glass_model i_lsc_glass_model (.pclk, .presetn, .clr, .led_mode, .bias_third,
    .com_drive, .com_level, .com_seen);
  function automatic logic [15:0] nxt_rand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [7:0] com_mask(input logic [1:0] duty, input logic share);
    if (duty == DUTY_8) return 8'hff;
    if (duty == DUTY_6) return 8'hfc;
    if (duty == DUTY_5) return 8'hf8;
    return share ? 8'h0f : 8'hf0;
  endfunction
  function automatic logic [NUM_SEG-1:0] seg_mask(input logic [1:0] duty, input logic share);
    if (duty == DUTY_8) return 28'hfff_fff0;
    if (duty == DUTY_6) return 28'hfff_fffc;
    if (duty == DUTY_5) return 28'hfff_fffe;
    return share ? 28'hfff_fff0 : 28'hfff_ffff;
  endfunction
  task automatic results;
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_errors++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // outputs are looked at only once the access edge has settled
    @(negedge pclk);
  endtask
  // a slot starts where the ladder drops back to the low-resistance setting
  task automatic wait_slot;
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (divider_resistance_eff === RES_100K && n < 2000);
    while (divider_resistance_eff !== RES_100K && n < 2000) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 2000) begin
      n_errors++;
      results();
    end
  endtask
  task automatic frame_mask(input logic [7:0] exp);
    int n;
    @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    @(negedge pclk);
    for (n = 0; n < 6000 && (com_seen & exp) !== exp; n++) @(negedge pclk);
    // linger so that a common outside the mask has time to show up
    repeat (64) @(negedge pclk);
    chk(com_seen, exp);
  endtask
  // -----------------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 8'h00);
      chk(rd, 32'h0000_0000);
    end
    repeat (6) begin
      for (int i = 0; i < 4; i++) begin
        lfsr = nxt_rand(lfsr);
        w[i] = (i == 0) ? (lfsr[7:0] & OC_WR_MASK) : lfsr[7:0];
        apb(1'b1, regs[i], lfsr[7:0]);
        apb(1'b0, regs[i], 8'h00);
        chk(rd, {24'h00_0000, w[i]});
      end
      chk({port3_pin_display_en, port2_pin_display_en, port1_pin_display_en, bias_third},
          {w[3], w[2], w[1], w[0][0]});
    end
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, IDX_SCAN_CTRL, i ? 8'h00 : 8'h40);
      chk(led_mode, i ? 1'b0 : 1'b1);
      apb(1'b1, i ? IDX_RAM_LAST : IDX_RAM_BASE, lfsr[7:0] ^ 8'h3c);
      apb(1'b0, i ? IDX_RAM_LAST : IDX_RAM_BASE, 8'h00);
      chk(rd, {24'h00_0000, lfsr[7:0] ^ 8'h3c});
    end
    apb(1'b1, IDX_RAM_LAST + 12'h001, 8'hff);
    chk(er, 1'b1);
    for (int i = 1; i < 4; i++) apb(1'b1, regs[i], 8'hff);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, IDX_OUT_CTRL, {4'h0, 2'h3, k == 4, 1'b0});
      apb(1'b1, IDX_SCAN_CTRL, {2'b10, (k > 3) ? DUTY_4 : k[1:0], 4'h0});
      wait_slot();
      wait_slot();
      chk(seg_drive, seg_mask((k > 3) ? DUTY_4 : k[1:0], k == 4));
      if (k == 0) begin
        repeat (6) @(negedge pclk);
        chk(divider_resistance_eff, RES_100K);
        repeat (200) @(negedge pclk);
        chk(divider_resistance_eff, 2'h3);
      end
      frame_mask(com_mask((k > 3) ? DUTY_4 : k[1:0], k == 4));
    end
    apb(1'b1, IDX_P1_EN, 8'h00);
    frame_mask(8'h00);
    apb(1'b1, IDX_P2_EN, 8'h0f);
    chk(seg_drive, 28'hfff_ff00);
    apb(1'b1, IDX_P1_EN, 8'hff);
    apb(1'b1, IDX_SCAN_CTRL, 8'h00);
    repeat (1200) @(posedge pclk);
    frame_mask(8'h00);
    results();
  end
endmodule

// ---- core/lsc_ctick.sv ----
// common-period slot timer for the display scan
// assumes tick_in is a one-cycle pulse in pclk domain at the scan rate
module lsc_ctick #(
  parameter int TICKS_PER_SLOT = 8
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // control
  input  wire logic run,
  input  wire logic tick_in,
  // status
  output logic      slot_end,
  output logic      first_16th
);
  import lsc_pkg::*;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  localparam logic [15:0] LAST = 16'(TICKS_PER_SLOT - 1);
  localparam logic [15:0] SIXT = 16'((TICKS_PER_SLOT + SUBSLOTS - 1) / SUBSLOTS);

  assign nxt_cnt  = (cnt_ff == LAST) ? 16'h0000 : cnt_ff + 16'h0001;
  assign slot_end = run && tick_in && (cnt_ff == LAST);
  // low-resistance boost window at the start of each common slot
  assign first_16th = run && (cnt_ff < SIXT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 16'h0000;
    end else if (ce) begin
      if (!run) begin
        cnt_ff <= 16'h0000;
      end else if (tick_in) begin
        cnt_ff <= nxt_cnt;
      end
    end
  end
endmodule

// ---- core/lsc_pkg.sv ----
// package for the lcd/led scan output block: register map, fields, timing
// assumes apb register access with 32-bit data; one register per word
package lsc_pkg;
  // ---------------------------------------------------------------------
  // register indices (printed offsets are not all word aligned)
  // ---------------------------------------------------------------------
  localparam logic [11:0] IDX_OUT_CTRL   = 12'h008f;
  localparam logic [11:0] IDX_P1_EN      = 12'h0094;
  localparam logic [11:0] IDX_P2_EN      = 12'h00a3;
  localparam logic [11:0] IDX_P3_EN      = 12'h00b3;
  localparam logic [11:0] IDX_SCAN_CTRL  = 12'h0093;
  localparam logic [11:0] IDX_SCAN_STAT  = 12'h00c0;
  localparam logic [11:0] IDX_RAM_BASE   = 12'h0700;
  localparam logic [11:0] IDX_RAM_LAST   = 12'h071b;
  localparam int          NUM_SEG        = 28;
  localparam int          NUM_COM        = 8;
  // ---------------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------------
  localparam int          OC_BIAS_BIT    = 0;
  localparam int          OC_SHARE_BIT   = 1;
  localparam int          OC_RES_LSB     = 2;
  localparam logic [7:0]  OC_WR_MASK     = 8'h0f;
  localparam int          SC_ENABLE_BIT  = 7;
  localparam int          SC_TYPE_BIT    = 6;
  localparam int          SC_DUTY_LSB    = 4;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [1:0]  DUTY_8         = 2'h0;
  localparam logic [1:0]  DUTY_6         = 2'h1;
  localparam logic [1:0]  DUTY_5         = 2'h2;
  localparam logic [1:0]  DUTY_4         = 2'h3;
  localparam logic [1:0]  RES_100K       = 2'h0;
  // ---------------------------------------------------------------------
  // timing: frame near 64 hz from the 32 khz scan tick
  // ---------------------------------------------------------------------
  localparam int          SCAN_HZ        = 32768;
  localparam int          FRAME_HZ       = 64;
  localparam int          TICKS_PER_FRAME = SCAN_HZ / FRAME_HZ;
  localparam int          SUBSLOTS       = 16;
  // drive level codes: 0..4 steps of the bias ladder
  typedef logic [2:0] lsc_lvl_t;
endpackage

// ---- core/lsc_scan.sv ----
// lcd/led segment-common scan driver with apb registers and display ram
// assumes scan_clk_in is the 32 khz source from another domain; pin muxing
// outside uses the per-pin enables and drive levels presented here
//
// Decided for this implementation: the APB interface to the registers.
module lsc_scan (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // scan clock
  input  wire logic        scan_clk_in,
  // pin enables
  output logic [7:0]       port1_pin_display_en,
  output logic [7:0]       port2_pin_display_en,
  output logic [7:0]       port3_pin_display_en,
  // analog ladder controls
  output logic [1:0]       divider_resistance_eff,
  output logic             bias_third,
  output logic             led_mode,
  // drive levels
  output lsc_pkg::lsc_lvl_t com_level [lsc_pkg::NUM_COM],
  output lsc_pkg::lsc_lvl_t seg_level [lsc_pkg::NUM_SEG],
  output logic [lsc_pkg::NUM_COM-1:0] com_drive,
  output logic [lsc_pkg::NUM_SEG-1:0] seg_drive
);
  import lsc_pkg::*;

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  logic [7:0] out_ctrl_ff, p1_en_ff, p2_en_ff, p3_en_ff, scan_ctrl_ff;
  logic [7:0] ram_ff [NUM_SEG];
  logic [11:0] idx;
  logic        acc, wr, rd_ok, ram_hit;
  logic [4:0]  ram_idx;

  assign idx     = paddr[13:2];
  assign acc     = psel && penable;
  assign wr      = acc && pwrite && ce && pstrb[0];
  assign ram_hit = (idx >= IDX_RAM_BASE) && (idx <= IDX_RAM_LAST);
  assign ram_idx = 5'(idx - IDX_RAM_BASE);
  assign pready  = 1'b1;

  function automatic logic known(input logic [11:0] i);
    known = (i == IDX_OUT_CTRL) || (i == IDX_P1_EN) || (i == IDX_P2_EN) ||
            (i == IDX_P3_EN) || (i == IDX_SCAN_CTRL) || (i == IDX_SCAN_STAT) ||
            ((i >= IDX_RAM_BASE) && (i <= IDX_RAM_LAST));
  endfunction

  assign rd_ok   = known(idx) && (paddr[1:0] == 2'b00);
  assign pslverr = acc && !rd_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p1_en_ff <= REG_RESET;
      p2_en_ff <= REG_RESET;
      p3_en_ff <= REG_RESET;
    end else if (wr && rd_ok) begin
      if (idx == IDX_P1_EN) p1_en_ff <= pwdata[7:0];
      if (idx == IDX_P2_EN) p2_en_ff <= pwdata[7:0];
      if (idx == IDX_P3_EN) p3_en_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ctrl_ff  <= REG_RESET;
      scan_ctrl_ff <= REG_RESET;
    end else if (wr && rd_ok) begin
      // bits 7..4 carry no function in this block and read as zero
      if (idx == IDX_OUT_CTRL) out_ctrl_ff <= pwdata[7:0] & OC_WR_MASK;
      if (idx == IDX_SCAN_CTRL) scan_ctrl_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_SEG; i++) ram_ff[i] <= REG_RESET;
    end else if (wr && ram_hit && rd_ok) begin
      ram_ff[ram_idx] <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------------
  // scan clock crossing and tick
  // ---------------------------------------------------------------------
  logic sclk_m_ff, sclk_s_ff, sclk_d_ff, tick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_m_ff <= 1'b0;
      sclk_s_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
    end else if (ce) begin
      sclk_m_ff <= scan_clk_in;
      sclk_s_ff <= sclk_m_ff;
      sclk_d_ff <= sclk_s_ff;
    end
  end
  assign tick = ce && sclk_s_ff && !sclk_d_ff;

  // ---------------------------------------------------------------------
  // controls decoded
  // ---------------------------------------------------------------------
  logic       run, share, first_16th, slot_end;
  logic [1:0] duty;
  logic [2:0] com_first, com_ff;
  logic [4:0] seg_first;
  logic       pol_ff;

  assign run      = scan_ctrl_ff[SC_ENABLE_BIT];
  assign led_mode = scan_ctrl_ff[SC_TYPE_BIT];
  assign duty     = scan_ctrl_ff[SC_DUTY_LSB +: 2];
  assign share    = out_ctrl_ff[OC_SHARE_BIT];
  assign bias_third = out_ctrl_ff[OC_BIAS_BIT];

  always_comb begin
    unique case (duty)
      DUTY_8: begin com_first = 3'd0; seg_first = 5'd4; end
      DUTY_6: begin com_first = 3'd2; seg_first = 5'd2; end
      DUTY_5: begin com_first = 3'd3; seg_first = 5'd1; end
      DUTY_4: begin
        com_first = share ? 3'd0 : 3'd4;
        seg_first = share ? 5'd4 : 5'd0;
      end
    endcase
  end
  wire [2:0] com_last = (duty == DUTY_4 && share) ? 3'd3 : 3'd7;

  lsc_ctick #(
    .TICKS_PER_SLOT (TICKS_PER_FRAME / NUM_COM)
  ) u_tick (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .run        (run),
    .tick_in    (tick),
    .slot_end   (slot_end),
    .first_16th (first_16th)
  );

  assign divider_resistance_eff = first_16th ? RES_100K
                                              : out_ctrl_ff[OC_RES_LSB +: 2];

  // ---------------------------------------------------------------------
  // common sequencer
  // ---------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      com_ff <= 3'd0;
      pol_ff <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        com_ff <= com_first;
        pol_ff <= 1'b0;
      end else if (slot_end) begin
        if (com_ff >= com_last || com_ff < com_first) begin
          com_ff <= com_first;
          pol_ff <= !pol_ff;
        end else begin
          com_ff <= com_ff + 3'd1;
        end
      end
    end
  end
  // ---------------------------------------------------------------------
  // drive level generation; lcd levels 0..4, led uses 0/4 as off/on
  // ---------------------------------------------------------------------
  function automatic lsc_lvl_t lcd_lvl(input logic is_com, input logic sel,
                                      input logic pol, input logic third);
    lsc_lvl_t top;
    top = third ? 3'd3 : 3'd4;
    if (is_com) lcd_lvl = sel ? (pol ? 3'd0 : top) : (pol ? (third ? 3'd2 : 3'd3) : 3'd1);
    else        lcd_lvl = sel ? (pol ? top : 3'd0) : (pol ? (third ? 3'd1 : 3'd2) : (third ? 3'd2 : 3'd2));
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_COM; g++) begin : g_com
      wire is_c = (3'(g) >= com_first) && (3'(g) <= com_last);
      wire act  = (3'(g) == com_ff);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          com_level[g] <= 3'd0;
        end else if (ce) begin
          com_level[g] <= !run ? 3'd0 : led_mode ? (act ? 3'd4 : 3'd0)
                         : lcd_lvl(1'b1, act, pol_ff, bias_third);
        end
      end
      assign com_drive[g] = run && is_c && ((g < 4) ? (g == 0 ? port1_pin_display_en[0]
                            : port1_pin_display_en[g]) : port1_pin_display_en[g]);
    end
    for (g = 0; g < NUM_SEG; g++) begin : g_seg
      wire on = ram_ff[g][com_ff];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          seg_level[g] <= 3'd0;
        end else if (ce) begin
          seg_level[g] <= !run ? 3'd0 : led_mode ? (on ? 3'd4 : 3'd0)
                         : lcd_lvl(1'b0, on, pol_ff, bias_third);
        end
      end
      // segment g sits on port2 (0..7), port3 (8..15), else ungated
      wire pin_en = (g < 8) ? port2_pin_display_en[g % 8]
                  : (g < 16) ? port3_pin_display_en[g % 8] : 1'b1;
      assign seg_drive[g] = run && (5'(g) >= seg_first) && pin_en;
    end
  endgenerate

  // ---------------------------------------------------------------------
  // outputs and read-back
  // ---------------------------------------------------------------------
  assign port1_pin_display_en = p1_en_ff;
  assign port2_pin_display_en = p2_en_ff;
  assign port3_pin_display_en = p3_en_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (paddr[13:2] == IDX_OUT_CTRL)  prdata[7:0] <= out_ctrl_ff;
      if (paddr[13:2] == IDX_P1_EN)     prdata[7:0] <= p1_en_ff;
      if (paddr[13:2] == IDX_P2_EN)     prdata[7:0] <= p2_en_ff;
      if (paddr[13:2] == IDX_P3_EN)     prdata[7:0] <= p3_en_ff;
      if (paddr[13:2] == IDX_SCAN_CTRL) prdata[7:0] <= scan_ctrl_ff;
      if (paddr[13:2] == IDX_SCAN_STAT) prdata[7:0] <= {pol_ff, 4'h0, com_ff};
      if ((paddr[13:2] >= IDX_RAM_BASE) && (paddr[13:2] <= IDX_RAM_LAST))
        prdata[7:0] <= ram_ff[5'(paddr[13:2] - IDX_RAM_BASE)];
    end
  end
endmodule
